// *** hdl/ocs_pkg.sv ***
// Package of constants and types for the oscillator control and status block
package ocs_pkg;
  // Register byte offsets on the Wishbone bus
  localparam logic [3:0] OCS_OFF_CONTROL   = 4'h0;
  localparam logic [3:0] OCS_OFF_STATUS    = 4'h4;
  localparam logic [3:0] OCS_OFF_IRQ_STAT  = 4'h8;
  localparam logic [3:0] OCS_OFF_IRQ_MASK  = 4'hc;

  // Control register field positions
  localparam int OCS_CTL_FREQ_LSB = 3;
  localparam int OCS_CTL_FREQ_MSB = 6;
  localparam int OCS_CTL_SEL_LSB  = 0;
  localparam int OCS_CTL_SEL_MSB  = 1;

  // Status register bit positions
  localparam int OCS_ST_SEC_RDY   = 7;
  localparam int OCS_ST_STARTUP   = 5;
  localparam int OCS_ST_HF_RDY    = 4;
  localparam int OCS_ST_LF_RDY    = 1;
  localparam int OCS_ST_HF_STABLE = 0;

  // Interrupt status and mask bit position
  localparam int OCS_IRQ_FAIL = 0;

  // Values after reset
  localparam logic [3:0] OCS_FREQ_RESET = 4'h7;
  localparam logic [1:0] OCS_SEL_RESET  = 2'h0;

  // Start-up count in external oscillations for crystal modes
  localparam logic [10:0] OCS_STARTUP_COUNT = 11'h400;

  // Idle cycles with every source off while the clock mux changes over
  localparam int OCS_SWITCH_GAP_NS = 20;
  localparam int OCS_CLK_PERIOD_NS = 10;
  localparam logic [1:0] OCS_SWITCH_GAP_CYC =
    2'((OCS_SWITCH_GAP_NS + OCS_CLK_PERIOD_NS - 1) / OCS_CLK_PERIOD_NS);

  // Oscillator mode configuration codes
  localparam logic [2:0] OCS_MODE_LP     = 3'h0;
  localparam logic [2:0] OCS_MODE_XT     = 3'h1;
  localparam logic [2:0] OCS_MODE_HS     = 3'h2;
  localparam logic [2:0] OCS_MODE_INTERNAL_OSC_OUT = 3'h4;

  // Source that feeds the internal oscillator output, before its divider
  typedef enum logic [1:0] {
    OCS_SRC_HF  = 2'h0,
    OCS_SRC_MF  = 2'h1,
    OCS_SRC_LF  = 2'h2
  } ocs_osc_src_t;

  // One-hot source enables of the system clock mux
  localparam logic [2:0] OCS_CLK_NONE = 3'h0;
  localparam logic [2:0] OCS_CLK_EXT  = 3'h1;
  localparam logic [2:0] OCS_CLK_SEC  = 3'h2;
  localparam logic [2:0] OCS_CLK_INT  = 3'h4;

  typedef enum logic [1:0] {
    OCS_SW_RUN = 2'b01,
    OCS_SW_GAP = 2'b10
  } ocs_sw_state_t;
endpackage

// *** hdl/ocs_sync.sv ***
// Two-flop synchroniser for a vector of unrelated level inputs
`timescale 1ns/1ps
module ocs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

// *** hdl/ocs_top.sv ***
// Oscillator control and status registers, start-up timer and clock select
//
// Function
// [RL1] Decode frequency select into source and rate, 16 MHz down to 31 kHz.
// [RL2] Codes 1010, 1001, 1000 come from the high-frequency internal source.
// [RL3] Reset loads frequency select with 0111 and clock select with 00.
// [RL4] Clock select 1x internal, 01 secondary, 00 configured oscillator mode.
// [RL5] Control bits 7 and 2 read zero and ignore writes.
// [RL6] With secondary enable set, status bit 7 shows secondary ready.
// [RL7] With secondary enable clear, status bit 7 reads one.
// [RL8] Status bit 5 is one when running from the configured clock.
// [RL9] Status bit 4 shows high-frequency internal oscillator ready.
// [RL10] Status bit 1 shows low-frequency internal oscillator ready.
// [RL11] Status bit 0 shows the 16 MHz oscillator stable and driving output.
// [RL12] External clock failure forces internal clock, sets fail flag, irq.
// [RL13] The fail-safe internal clock follows the frequency select field.
// [RL14] Crystal modes count 1024 oscillations before external use.
// [RL15] Software waits for secondary ready before selecting secondary.
// [RL16] Clock mux switches with all sources off between old and new.
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module ocs_top
  import ocs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [2:0]  cfg_osc_mode,
  input  wire logic        sec_osc_enable,
  input  wire logic        sec_osc_ready_in,
  input  wire logic        hf_osc_ready_in,
  input  wire logic        lf_osc_ready_in,
  input  wire logic        hf_osc_stable_in,
  input  wire logic        ext_osc_clk_in,
  input  wire logic        fail_safe_monitor_fail,
  output logic      [3:0]  int_osc_freq_sel,
  output logic      [1:0]  sys_clk_sel,
  output logic      [1:0]  int_osc_src,
  output logic      [2:0]  int_osc_div_log2,
  output logic      [2:0]  clk_src_en,
  output logic             fail_safe_active,
  output logic             irq
);
  logic [5:0] pin_sync;
  logic       sec_rdy_s;
  logic       hf_rdy_s;
  logic       lf_rdy_s;
  logic       hf_stable_s;
  logic       ext_clk_s;
  logic       fail_s;

  // Every pin input is asynchronous to clk
  ocs_sync #(.W(6)) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({fail_safe_monitor_fail, ext_osc_clk_in, hf_osc_stable_in,
                lf_osc_ready_in, hf_osc_ready_in, sec_osc_ready_in}),
    .sync_out (pin_sync)
  );

  assign sec_rdy_s   = pin_sync[0];
  assign hf_rdy_s    = pin_sync[1];
  assign lf_rdy_s    = pin_sync[2];
  assign hf_stable_s = pin_sync[3];
  assign ext_clk_s   = pin_sync[4];
  assign fail_s      = pin_sync[5];

  // Bus access: ack follows a request by one cycle, writes land on ack
  logic        ack_q;
  logic        ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        wr_en;
  logic        lane0;

  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
  assign lane0 = wb_sel_i[0];

  // Control and interrupt registers
  logic [3:0] freq_q;
  logic [3:0] freq_d;
  logic [1:0] sel_q;
  logic [1:0] sel_d;
  logic       fail_flag_q;
  logic       fail_flag_d;
  logic       fail_en_q;
  logic       fail_en_d;
  logic       sel_changed;

  // Start-up timer and fail-safe state
  logic        ext_clk_prev_q;
  logic        ext_clk_prev_d;
  logic [10:0] ost_cnt_q;
  logic [10:0] ost_cnt_d;
  logic        ost_done_q;
  logic        ost_done_d;
  logic        fsafe_q;
  logic        fsafe_d;
  logic        crystal_mode;
  logic        mode_internal;
  logic        on_external;
  logic        fail_event;

  assign crystal_mode  = (cfg_osc_mode == OCS_MODE_LP) |
                         (cfg_osc_mode == OCS_MODE_XT) |
                         (cfg_osc_mode == OCS_MODE_HS);
  assign mode_internal = (cfg_osc_mode == OCS_MODE_INTERNAL_OSC_OUT);
  // Running from the configured clock only after start-up and without fault
  assign on_external   = (sel_q == 2'h0) & ~mode_internal & ost_done_q &
                         ~fsafe_q; // [RL8]
  // The monitor is only trusted once the start-up timer has expired
  assign fail_event    = fail_s & on_external; // [RL12]

  always_comb begin
    freq_d      = freq_q;
    sel_d       = sel_q;
    fail_en_d   = fail_en_q;
    fail_flag_d = fail_flag_q;
    sel_changed = 1'b0;
    if (wr_en && lane0) begin
      if (wb_adr_i == OCS_OFF_CONTROL) begin
        // Bits 7 and 2 have no storage
        freq_d      = wb_dat_i[OCS_CTL_FREQ_MSB:OCS_CTL_FREQ_LSB]; // [RL5]
        sel_d       = wb_dat_i[OCS_CTL_SEL_MSB:OCS_CTL_SEL_LSB]; // [RL5]
        sel_changed = (sel_d != sel_q);
      end else if (wb_adr_i == OCS_OFF_IRQ_STAT) begin
        if (wb_dat_i[OCS_IRQ_FAIL]) begin
          fail_flag_d = 1'b0;
        end
      end else if (wb_adr_i == OCS_OFF_IRQ_MASK) begin
        fail_en_d = wb_dat_i[OCS_IRQ_FAIL];
      end
    end
    // A failure in the clearing cycle keeps the flag set
    if (fail_event) begin
      fail_flag_d = 1'b1; // [RL12]
    end
  end

  always_comb begin
    ext_clk_prev_d = ext_clk_s;
    ost_cnt_d      = ost_cnt_q;
    ost_done_d     = ost_done_q;
    fsafe_d        = fsafe_q;
    if (sel_changed) begin
      // New selection restarts start-up and clears the fail-safe state
      ost_cnt_d  = 11'h000;
      ost_done_d = 1'b0;
      fsafe_d    = 1'b0;
    end else begin
      if (!crystal_mode) begin
        ost_done_d = 1'b1;
      end else if (!ost_done_q && ext_clk_s && !ext_clk_prev_q) begin
        ost_cnt_d = ost_cnt_q + 11'h001;
        if (ost_cnt_d == OCS_STARTUP_COUNT) begin
          ost_done_d = 1'b1; // [RL14]
        end
      end
      if (fail_event) begin
        fsafe_d = 1'b1; // [RL12]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      freq_q         <= OCS_FREQ_RESET; // [RL3]
      sel_q          <= OCS_SEL_RESET; // [RL3]
      fail_flag_q    <= 1'b0;
      fail_en_q      <= 1'b0;
      ext_clk_prev_q <= 1'b0;
      ost_cnt_q      <= 11'h000;
      ost_done_q     <= 1'b0;
      fsafe_q        <= 1'b0;
    end else begin
      freq_q         <= freq_d;
      sel_q          <= sel_d;
      fail_flag_q    <= fail_flag_d;
      fail_en_q      <= fail_en_d;
      ext_clk_prev_q <= ext_clk_prev_d;
      ost_cnt_q      <= ost_cnt_d;
      ost_done_q     <= ost_done_d;
      fsafe_q        <= fsafe_d;
    end
  end

  // Status register image
  logic [7:0] status;
  always_comb begin
    status                   = 8'h00;
    // The timer clock counts as ready while its oscillator is off
    status[OCS_ST_SEC_RDY]   = sec_osc_enable ? sec_rdy_s : 1'b1; // [RL6] [RL7]
    status[OCS_ST_STARTUP]   = on_external; // [RL8]
    status[OCS_ST_HF_RDY]    = hf_rdy_s; // [RL9]
    status[OCS_ST_LF_RDY]    = lf_rdy_s; // [RL10]
    status[OCS_ST_HF_STABLE] = hf_stable_s; // [RL11]
  end

  always_comb begin
    ack_d   = wb_cyc_i & wb_stb_i & ~ack_q;
    rdata_d = 32'h0000_0000;
    if (wb_adr_i == OCS_OFF_CONTROL) begin
      rdata_d[OCS_CTL_FREQ_MSB:OCS_CTL_FREQ_LSB] = freq_q; // [RL5]
      rdata_d[OCS_CTL_SEL_MSB:OCS_CTL_SEL_LSB]   = sel_q;
    end else if (wb_adr_i == OCS_OFF_STATUS) begin
      rdata_d[7:0] = status;
    end else if (wb_adr_i == OCS_OFF_IRQ_STAT) begin
      rdata_d[OCS_IRQ_FAIL] = fail_flag_q;
    end else if (wb_adr_i == OCS_OFF_IRQ_MASK) begin
      rdata_d[OCS_IRQ_FAIL] = fail_en_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // Frequency decode: source and power-of-two divide of that source
  always_comb begin
    int_osc_src      = OCS_SRC_LF;
    int_osc_div_log2 = 3'h0;
    if (freq_q[3]) begin
      // Upper half runs from the high-frequency source, 16 MHz down
      int_osc_src      = OCS_SRC_HF; // [RL2]
      int_osc_div_log2 = 3'h7 - freq_q[2:0]; // [RL1] [RL2]
    end else if (freq_q[2]) begin
      // 0111 to 0100: 500 kHz mid source divided down to 62.5 kHz
      int_osc_src      = OCS_SRC_MF; // [RL1]
      int_osc_div_log2 = {1'b0, 2'h3 - freq_q[1:0]}; // [RL1]
    end else if (freq_q[1]) begin
      int_osc_src      = OCS_SRC_MF; // [RL1]
      int_osc_div_log2 = 3'h4; // [RL1]
    end
  end

  // Clock source request
  logic [2:0] want_src;
  always_comb begin
    if (fsafe_q || sel_q[1]) begin
      // Fail-safe uses the internal rate that software already chose
      want_src = OCS_CLK_INT; // [RL4] [RL13]
    end else if (sel_q == 2'h1) begin
      // Readiness of the secondary source is the caller's concern
      want_src = OCS_CLK_SEC; // [RL4] [RL15]
    end else if (on_external) begin
      want_src = OCS_CLK_EXT; // [RL4]
    end else begin
      // Two-speed start: internal until the start-up timer expires
      want_src = OCS_CLK_INT; // [RL4] [RL14]
    end
  end

  // Break-before-make switch of the clock mux enables
  ocs_sw_state_t sw_q;
  ocs_sw_state_t sw_d;
  logic [2:0]    en_q;
  logic [2:0]    en_d;
  logic [1:0]    gap_q;
  logic [1:0]    gap_d;

  always_comb begin
    sw_d  = sw_q;
    en_d  = en_q;
    gap_d = gap_q;
    case (sw_q)
      OCS_SW_RUN: begin
        if (want_src != en_q) begin
          en_d  = OCS_CLK_NONE; // [RL16]
          gap_d = OCS_SWITCH_GAP_CYC;
          sw_d  = OCS_SW_GAP;
        end
      end
      OCS_SW_GAP: begin
        if (gap_q > 2'h1) begin
          gap_d = gap_q - 2'h1;
        end else begin
          en_d = want_src; // [RL16]
          sw_d = OCS_SW_RUN;
        end
      end
      default: begin
        en_d = OCS_CLK_NONE;
        sw_d = OCS_SW_GAP;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sw_q  <= OCS_SW_RUN;
      en_q  <= OCS_CLK_INT;
      gap_q <= 2'h0;
    end else begin
      sw_q  <= sw_d;
      en_q  <= en_d;
      gap_q <= gap_d;
    end
  end

  assign wb_ack_o         = ack_q;
  assign wb_dat_o         = rdata_q;
  assign int_osc_freq_sel = freq_q;
  assign sys_clk_sel      = sel_q;
  assign clk_src_en       = en_q;
  assign fail_safe_active = fsafe_q;
  assign irq              = fail_flag_q & fail_en_q; // [RL12]
endmodule

// *** verification/ocs_top_checker.sv ***
// Port-level assertions for the oscillator control block
`timescale 1ns/1ps
module ocs_top_checker
  import ocs_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [2:0]  cfg_osc_mode,
  input wire logic        sec_osc_enable,
  input wire logic [3:0]  int_osc_freq_sel,
  input wire logic [1:0]  sys_clk_sel,
  input wire logic [1:0]  int_osc_src,
  input wire logic [2:0]  int_osc_div_log2,
  input wire logic [2:0]  clk_src_en,
  input wire logic        fail_safe_active,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire rd_ack = wb_ack_o && !wb_we_i;

  a_reset_vals: assert property ($past(rst) |->
    int_osc_freq_sel == 4'h7 && sys_clk_sel == 2'h0)
    else $error("Reset values wrong");
  a_ctl_read: assert property (rd_ack && wb_adr_i == OCS_OFF_CONTROL |->
    !wb_dat_o[7] && !wb_dat_o[2] && wb_dat_o[6:3] == int_osc_freq_sel)
    else $error("Control read wrong");
  a_sec_free: assert property ((!sec_osc_enable) [*3] ##0
    (rd_ack && wb_adr_i == OCS_OFF_STATUS) |-> wb_dat_o[7])
    else $error("Secondary ready not forced");
  a_bit5_src: assert property (rd_ack && wb_adr_i == OCS_OFF_STATUS
    && wb_dat_o[5] |-> sys_clk_sel == 2'h0
    && cfg_osc_mode != OCS_MODE_INTERNAL_OSC_OUT)
    else $error("Start-up status without configured clock");
  a_dec_dup: assert property (int_osc_freq_sel[3] |->
    int_osc_src == OCS_SRC_HF && int_osc_div_log2 == ~int_osc_freq_sel[2:0])
    else $error("High range decode wrong");
  a_mux_onehot: assert property ($onehot0(clk_src_en))
    else $error("Mux enables overlap");
  a_mux_gap: assert property ($past(clk_src_en) != 3'h0 &&
    $changed(clk_src_en) |-> clk_src_en == 3'h0)
    else $error("Mux switched without gap");
  a_sel_sec: assert property ((sys_clk_sel == 2'h1) [*5] |->
    clk_src_en == OCS_CLK_SEC)
    else $error("Secondary not selected");
  a_sel_int: assert property (sys_clk_sel[1] [*5] |->
    clk_src_en == OCS_CLK_INT)
    else $error("Internal not selected");
  a_fail_int: assert property (fail_safe_active [*5] |->
    clk_src_en == OCS_CLK_INT)
    else $error("Fail-safe not on internal clock");

  c_fail: cover property ($rose(fail_safe_active));
  c_sec: cover property (clk_src_en == OCS_CLK_SEC);
  c_irq: cover property (irq);
endmodule

bind ocs_top ocs_top_checker i_chk (
  .clk              (clk),
  .rst              (rst),
  .wb_we_i          (wb_we_i),
  .wb_adr_i         (wb_adr_i),
  .wb_dat_o         (wb_dat_o),
  .wb_ack_o         (wb_ack_o),
  .cfg_osc_mode     (cfg_osc_mode),
  .sec_osc_enable   (sec_osc_enable),
  .int_osc_freq_sel (int_osc_freq_sel),
  .sys_clk_sel      (sys_clk_sel),
  .int_osc_src      (int_osc_src),
  .int_osc_div_log2 (int_osc_div_log2),
  .clk_src_en       (clk_src_en),
  .fail_safe_active (fail_safe_active),
  .irq              (irq)
);

// *** verification/test_ocs_top.sv ***
// Self-checking bench for the oscillator control block
`timescale 1ns/1ps
module test_ocs_top;
  import ocs_pkg::*;
  logic        clk = 0;
  logic        rst = 1;
  logic        cyc = 0;
  logic        stb = 0;
  logic        we = 0;
  logic        sec_en = 0;
  logic        ext = 0;
  logic        fail = 0;
  logic [3:0]  adr = 0;
  logic [3:0]  wsel = 0;
  logic [3:0]  lanes = 4'hf;
  logic [2:0]  mode = OCS_MODE_XT;
  logic [3:0]  rdy = 0;
  logic [31:0] wdat = 0;
  logic [31:0] rd;
  logic [31:0] dat_o;
  logic        ack;
  logic        fs;
  logic        irq;
  logic [3:0]  freq;
  logic [1:0]  sel;
  logic [1:0]  src;
  logic [2:0]  div;
  logic [2:0]  en;
  int          err_total = 0;
  int          compares = 0;
  int          seed = 32'h7d47a573;
  int          ctl;

  ocs_top i_dut (
    .clk                    (clk),
    .rst                    (rst),
    .wb_cyc_i               (cyc),
    .wb_stb_i               (stb),
    .wb_we_i                (we),
    .wb_adr_i               (adr),
    .wb_sel_i               (wsel),
    .wb_dat_i               (wdat),
    .wb_dat_o               (dat_o),
    .wb_ack_o               (ack),
    .cfg_osc_mode           (mode),
    .sec_osc_enable         (sec_en),
    .sec_osc_ready_in       (rdy[0]),
    .hf_osc_ready_in        (rdy[1]),
    .lf_osc_ready_in        (rdy[2]),
    .hf_osc_stable_in       (rdy[3]),
    .ext_osc_clk_in         (ext),
    .fail_safe_monitor_fail (fail),
    .int_osc_freq_sel       (freq),
    .sys_clk_sel            (sel),
    .int_osc_src            (src),
    .int_osc_div_log2       (div),
    .clk_src_en             (en),
    .fail_safe_active       (fs),
    .irq                    (irq)
  );

  always #5 clk = ~clk;

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Classic single cycle; held until ack is sampled high
  task automatic bus(input int w, input logic [3:0] a, input int d);
    int n;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    wsel <= lanes;
    we <= w[0];
    adr <= a;
    wdat <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (ack === 1'b1)
        break;
    end
    rd = dat_o;
    cyc <= 0;
    stb <= 0;
    if (n == 20) begin
      err_total++;
      summarize();
    end
  endtask

  task automatic rdchk(input string nm, input logic [3:0] a, input int e);
    bus(0, a, 0);
    chk(nm, rd, e);
  endtask

  // Expected {source, divide exponent} of a frequency code
  function automatic logic [4:0] dec(input logic [3:0] f);
    if (f[3])
      return {2'h0, 3'(15 - f)};
    if (f >= 4)
      return {2'h1, 3'(7 - f)};
    if (f >= 2)
      return {2'h1, 3'h4};
    return {2'h2, 3'h0};
  endfunction

  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    summarize();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    chk("rst pins", {freq, sel, en, fs, irq, ack},
        {OCS_FREQ_RESET, OCS_SEL_RESET, OCS_CLK_INT, 3'b000});
    rdchk("ctl", OCS_OFF_CONTROL, 32'h38);
    rdchk("mask", OCS_OFF_IRQ_MASK, 0);
    bus(1, 4'h1, 32'hff);
    rdchk("unmapped", 4'h1, 0);
    // A write without the low byte lane must leave the register alone
    lanes = 4'he;
    bus(1, OCS_OFF_CONTROL, 32'h7a);
    lanes = 4'hf;
    rdchk("no lane", OCS_OFF_CONTROL, 32'h38);
    $display("test reset done");
    for (int f = 0; f < 16; f++) begin
      ctl = f * 8 + 2;
      bus(1, OCS_OFF_CONTROL, ($random(seed) & 32'hffffff84) | ctl);
      @(posedge clk);
      chk("decode", {src, div}, dec(4'(f)));
      chk("fields", {freq, sel}, {4'(f), 2'h2});
      rdchk("ctl", OCS_OFF_CONTROL, ctl);
    end
    chk("mux int", en, OCS_CLK_INT);
    $display("test decode done");
    sec_en <= 1;
    for (int i = 0; i < 6; i++) begin
      rdy <= 4'($random(seed));
      repeat (4) @(posedge clk);
      rdchk("status", OCS_OFF_STATUS,
            {rdy[0], 2'b0, rdy[1], 2'b0, rdy[2], rdy[3]});
    end
    sec_en <= 0;
    rdy <= 0;
    repeat (4) @(posedge clk);
    rdchk("sec off", OCS_OFF_STATUS, 32'h80);
    sec_en <= 1;
    rdy <= 4'hf;
    repeat (4) @(posedge clk);
    rdchk("sec ready", OCS_OFF_STATUS, 32'h93);
    // Secondary chosen only once its ready status was seen
    bus(1, OCS_OFF_CONTROL, 32'h39);
    repeat (6) @(posedge clk);
    chk("mux sec", en, OCS_CLK_SEC);
    $display("test status done");
    bus(1, OCS_OFF_CONTROL, 32'h38);
    bus(1, OCS_OFF_IRQ_MASK, 1);
    // Slow external clock so every edge survives the synchroniser
    for (int i = 0; i < 1024; i++) begin
      if (i == 1023)
        rdchk("early", OCS_OFF_STATUS, 32'h93);
      ext <= 1;
      repeat (3) @(posedge clk);
      ext <= 0;
      repeat (3) @(posedge clk);
    end
    rdchk("started", OCS_OFF_STATUS, 32'hb3);
    repeat (6) @(posedge clk);
    chk("mux ext", en, OCS_CLK_EXT);
    $display("test start-up done");
    fail <= 1;
    repeat (8) @(posedge clk);
    chk("fail", {fs, irq, en, src},
        {2'b11, OCS_CLK_INT, OCS_SRC_MF});
    fail <= 0;
    rdchk("flag", OCS_OFF_IRQ_STAT, 1);
    bus(1, OCS_OFF_IRQ_MASK, 0);
    @(posedge clk);
    chk("masked", irq, 0);
    bus(1, OCS_OFF_IRQ_STAT, 1);
    rdchk("cleared", OCS_OFF_IRQ_STAT, 0);
    // Rate change without a select change keeps the fail-safe state
    bus(1, OCS_OFF_CONTROL, 32'h78);
    chk("fs held", fs, 1);
    $display("test fail-safe done");
    rst <= 1;
    mode <= OCS_MODE_INTERNAL_OSC_OUT;
    repeat (3) @(posedge clk);
    rst <= 0;
    rdchk("ctl again", OCS_OFF_CONTROL, 32'h38);
    chk("fs again", fs, 0);
    rdchk("int mode", OCS_OFF_STATUS, 32'h93);
    // Non-crystal external mode needs no start-up count
    mode <= 3'h3;
    repeat (4) @(posedge clk);
    rdchk("ext mode", OCS_OFF_STATUS, 32'hb3);
    $display("test second reset done");
    summarize();
  end
endmodule
